/* inc/bk2cfg_pkg.sv */
// Package: addresses, field layouts, reset values and types of the buck 2 config block
package bk2cfg_pkg;

	localparam int AVS_AW = 18;
	localparam int AVS_DW = 32;

	// Register indices; the byte address is four times the index
	localparam logic [15:0] IDX_ACTIVE = 16'h405D;
	localparam logic [15:0] IDX_SLEEP = 16'h405E;
	localparam logic [15:0] IDX_STATUS = 16'h4100;
	localparam logic [AVS_AW-1:0] ADDR_ACTIVE = {IDX_ACTIVE, 2'h0};
	localparam logic [AVS_AW-1:0] ADDR_SLEEP = {IDX_SLEEP, 2'h0};
	localparam logic [AVS_AW-1:0] ADDR_STATUS = {IDX_STATUS, 2'h0};

	// Layout shared by both configuration registers
	typedef struct packed {
		logic [2:0] slot;
		logic [2:0] rsv_hi;
		logic [1:0] mode;
		logic rsv_mid;
		logic [6:0] volt;
	} bk2cfg_reg_t;

	localparam logic [15:0] CFG_WMASK = 16'hE37F;
	localparam logic [15:0] ACTIVE_RST = 16'h0100;
	localparam logic [15:0] SLEEP_RST = 16'h0300;
	localparam logic [15:0] UNMAPPED_RDATA = 16'h0000;

	// Operating modes, same for active and sleep
	localparam logic [1:0] MODE_FCCM = 2'h0;
	localparam logic [1:0] MODE_AUTO = 2'h1;
	localparam logic [1:0] MODE_LDO = 2'h2;
	localparam logic [1:0] MODE_HYST = 2'h3;

	// Slot codes
	localparam logic [2:0] SLOT_NONE = 3'h0;
	localparam logic [2:0] SLOT_FIRST = 3'h1;
	localparam logic [2:0] SLOT_LAST = 3'h5;
	localparam logic [2:0] SLOT_HW1 = 3'h6;
	localparam logic [2:0] SLOT_HW2 = 3'h7;
	localparam logic [2:0] SLP_CODE_KEEP5 = 3'h0;
	localparam logic [2:0] SLP_CODE_KEEP3 = 3'h6;
	localparam logic [2:0] SLP_CODE_KEEP1 = 3'h7;
	localparam logic [2:0] TSLOT_1 = 3'h1;
	localparam logic [2:0] TSLOT_3 = 3'h3;
	localparam logic [2:0] TSLOT_5 = 3'h5;
	localparam logic [2:0] SLP_REV_BASE = 3'h6;

	// Voltage code mapping, output in units of 0.1 mV
	localparam logic [6:0] VCODE_FLOOR = 7'h08;
	localparam logic [6:0] VCODE_CEIL = 7'h68;
	localparam logic [6:0] VCODE_HIFREQ_MAX = 7'h48;
	localparam logic [14:0] VOLT_MIN = 15'h1770;
	localparam logic [14:0] VOLT_MAX = 15'h4650;
	localparam logic [14:0] VOLT_STEP = 15'h007D;

	// Switching frequency field
	localparam logic [1:0] FREQ_LOW = 2'h1;
	localparam logic [1:0] FREQ_HIGH = 2'h2;

	// Status register bits
	localparam int STAT_FREQ_LSB = 0;
	localparam int STAT_ACT_OVER = 2;
	localparam int STAT_SLP_OVER = 3;

	typedef enum logic [1:0] {SRC_OFF, SRC_SLOT, SRC_HW1, SRC_HW2} bk2cfg_src_t;
	typedef enum logic [1:0] {SLP_TRANSITION, SLP_DISABLE, SLP_HW_ENTER} bk2cfg_slp_act_t;

	typedef struct packed {
		logic strobe;
		logic [4:0] volt_hi;
	} bk2cfg_load_t;

	typedef struct packed {
		bk2cfg_src_t act_src;
		logic [2:0] act_slot;
		logic [1:0] act_mode;
		logic [6:0] act_volt;
		bk2cfg_slp_act_t slp_action;
		logic [2:0] slp_slot;
		logic [1:0] slp_mode;
		logic [6:0] slp_volt;
	} bk2cfg_out_t;

endpackage : bk2cfg_pkg

/* verilog/bk2cfg_vdecode.sv */
// Voltage code to output level in 0.1 mV units, registered
module bk2cfg_vdecode
	import bk2cfg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [6:0] code,
	output logic [14:0] volt_r
);

	logic [6:0] above_floor;
	logic [14:0] volt_nxt;

	assign above_floor = code - VCODE_FLOOR;
	assign volt_nxt = (code <= VCODE_FLOOR) ? VOLT_MIN :
		(code >= VCODE_CEIL) ? VOLT_MAX :
		15'(VOLT_MIN + 15'(above_floor) * VOLT_STEP);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			volt_r <= VOLT_MIN;
		end else begin
			volt_r <= volt_nxt;
		end
	end

	sat_top_a: assert property (@(posedge clk_sys) disable iff (rst)
		code >= VCODE_CEIL |=> volt_r == VOLT_MAX)
		else $error("code above ceiling did not saturate");

	floor_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		code <= VCODE_FLOOR |=> volt_r == VOLT_MIN)
		else $error("code below floor did not give minimum");

endmodule : bk2cfg_vdecode

/* verilog/bk2cfg_regs.sv */
// Buck 2 active and sleep configuration registers behind an Avalon-MM slave
// Summary of operation
// - Active slot resets 000 (never enabled); 001..101 enable in timeslots 1..5.
// - Active slot 110 gives enable to hardware input 1, 111 to input 2.
// - Active mode: 00 forced CCM, 01 auto, 10 LDO, 11 hysteretic; resets 01.
// - Voltage code 00h-08h is 0.6V, +12.5mV per code, 68h-7Fh 1.8V.
// - Config store loads active code bits 6:2 only, 50mV steps.
// - Sleep slot 000 (reset) transitions in slot 5, 110 slot 3, 111 slot 1.
// - Sleep slot 001..101 disable the converter in slots 5 down to 1.
// - With hardware enable, sleep codes 001..101 choose the sleep-entry timeslot instead.
// - Sleep mode uses the same mode encoding but resets to 11.
// - Sleep voltage code bits 6:0 reset zero, same voltage mapping.
// - Frequency field 10 selects the high frequency, 01 the low one.
//
// Implementation choice: the Avalon-MM slave port.
module bk2cfg_regs
	import bk2cfg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [AVS_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [AVS_DW-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [AVS_DW-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [1:0] switch_freq_sel,
	input wire bk2cfg_load_t cfg_load,
	output bk2cfg_out_t cfg_out,
	output logic [14:0] active_volt_level,
	output logic [14:0] sleep_volt_level
);

	bk2cfg_reg_t active_r;
	bk2cfg_reg_t active_nxt;
	bk2cfg_reg_t sleep_r;
	bk2cfg_reg_t sleep_nxt;
	logic ack_r;
	logic [AVS_DW-1:0] rdata_r;
	bk2cfg_out_t out_r;
	bk2cfg_out_t out_nxt;

	// Bus decode
	wire req = avs_read | avs_write;
	wire first_cycle = req & ~ack_r;
	wire commit_wr = avs_write & ack_r;
	wire hit_active = avs_address == ADDR_ACTIVE;
	wire hit_sleep = avs_address == ADDR_SLEEP;
	wire hit_status = avs_address == ADDR_STATUS;
	wire [15:0] lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [15:0] wdata16 = avs_writedata[15:0];
	wire [15:0] active_merged = ((active_r & ~lane_mask) | (wdata16 & lane_mask)) & CFG_WMASK;
	wire [15:0] sleep_merged = ((sleep_r & ~lane_mask) | (wdata16 & lane_mask)) & CFG_WMASK;

	// Frequency limit status; software is expected to keep within it
	wire high_freq = switch_freq_sel == FREQ_HIGH;
	wire act_over = high_freq & (active_r.volt > VCODE_HIFREQ_MAX);
	wire slp_over = high_freq & (sleep_r.volt > VCODE_HIFREQ_MAX);
	wire [15:0] status_word = (16'(act_over) << STAT_ACT_OVER) | (16'(slp_over) << STAT_SLP_OVER)
		| (16'(switch_freq_sel) << STAT_FREQ_LSB);

	wire [15:0] rd_sel = hit_active ? 16'(active_r & CFG_WMASK) :
		hit_sleep ? 16'(sleep_r & CFG_WMASK) :
		hit_status ? status_word : UNMAPPED_RDATA;

	// One wait state: data registered on the first cycle, taken on the second
	assign avs_waitrequest = req & ~ack_r;
	assign avs_readdata = rdata_r;

	// Load from the config store brings only bits 6:2; bus write in the same cycle wins
	always_comb begin
		active_nxt = active_r;
		if (cfg_load.strobe) begin
			active_nxt.volt = {cfg_load.volt_hi, 2'h0};
		end
		if (commit_wr & hit_active) begin
			active_nxt = bk2cfg_reg_t'(active_merged);
		end
	end

	always_comb begin
		sleep_nxt = sleep_r;
		if (commit_wr & hit_sleep) begin
			sleep_nxt = bk2cfg_reg_t'(sleep_merged);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			active_r <= bk2cfg_reg_t'(ACTIVE_RST);
			sleep_r <= bk2cfg_reg_t'(SLEEP_RST);
		end else begin
			active_r <= active_nxt;
			sleep_r <= sleep_nxt;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
			rdata_r <= '0;
		end else begin
			ack_r <= first_cycle;
			if (first_cycle) begin
				rdata_r <= {16'h0000, rd_sel};
			end
		end
	end

	// Decode of the active enable source
	wire act_in_slots = (active_r.slot >= SLOT_FIRST) && (active_r.slot <= SLOT_LAST);
	wire act_hw = (active_r.slot == SLOT_HW1) || (active_r.slot == SLOT_HW2);
	wire slp_in_slots = (sleep_r.slot >= SLOT_FIRST) && (sleep_r.slot <= SLOT_LAST);

	always_comb begin
		out_nxt = '0;
		out_nxt.act_mode = active_r.mode;
		out_nxt.act_volt = active_r.volt;
		out_nxt.slp_mode = sleep_r.mode;
		out_nxt.slp_volt = sleep_r.volt;
		out_nxt.act_slot = SLOT_NONE;
		if (act_in_slots) begin
			out_nxt.act_src = SRC_SLOT;
			out_nxt.act_slot = active_r.slot;
		end else if (active_r.slot == SLOT_HW1) begin
			out_nxt.act_src = SRC_HW1;
		end else if (active_r.slot == SLOT_HW2) begin
			out_nxt.act_src = SRC_HW2;
		end else begin
			out_nxt.act_src = SRC_OFF;
		end
		// Reverse order: code 1 is the last slot
		if (slp_in_slots) begin
			out_nxt.slp_action = act_hw ? SLP_HW_ENTER : SLP_DISABLE;
			out_nxt.slp_slot = 3'(SLP_REV_BASE - sleep_r.slot);
		end else if (sleep_r.slot == SLP_CODE_KEEP3) begin
			out_nxt.slp_action = SLP_TRANSITION;
			out_nxt.slp_slot = TSLOT_3;
		end else if (sleep_r.slot == SLP_CODE_KEEP1) begin
			out_nxt.slp_action = SLP_TRANSITION;
			out_nxt.slp_slot = TSLOT_1;
		end else begin
			out_nxt.slp_action = SLP_TRANSITION;
			out_nxt.slp_slot = TSLOT_5;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			out_r <= '0;
		end else begin
			out_r <= out_nxt;
		end
	end

	assign cfg_out = out_r;

	bk2cfg_vdecode u_act_vdec (
		.clk_sys(clk_sys),
		.rst(rst),
		.code(active_r.volt),
		.volt_r(active_volt_level)
	);

	bk2cfg_vdecode u_slp_vdec (
		.clk_sys(clk_sys),
		.rst(rst),
		.code(sleep_r.volt),
		.volt_r(sleep_volt_level)
	);

	// Bus handshake: one wait cycle, then release
	sequence req_new_s;
		req && !ack_r;
	endsequence
	sequence req_done_s;
		!avs_waitrequest;
	endsequence

	one_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
		req_new_s ##0 avs_waitrequest |=> req_done_s)
		else $error("request not answered after one wait cycle");

	rsv_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
		avs_read && !avs_waitrequest |-> (avs_readdata & ~{16'h0000, CFG_WMASK}) == '0)
		else $error("unassigned bits read non-zero");

	act_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
		commit_wr && hit_active && avs_byteenable[1:0] == 2'h3
		|=> active_r == bk2cfg_reg_t'($past(avs_writedata[15:0]) & CFG_WMASK))
		else $error("active register write lost");

	load_hi_a: assert property (@(posedge clk_sys) disable iff (rst)
		cfg_load.strobe && !(commit_wr && hit_active)
		|=> active_r.volt == {$past(cfg_load.volt_hi), 2'h0})
		else $error("config store load wrong");

	slot_dec_a: assert property (@(posedge clk_sys) disable iff (rst)
		act_in_slots |=> out_r.act_src == SRC_SLOT && out_r.act_slot == $past(active_r.slot))
		else $error("active timeslot decode wrong");

	hw_src_a: assert property (@(posedge clk_sys) disable iff (rst)
		active_r.slot == SLOT_HW2 |=> out_r.act_src == SRC_HW2)
		else $error("hardware enable 2 not selected");

	slp_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
		sleep_r.slot == SLP_CODE_KEEP3 |=> out_r.slp_action == SLP_TRANSITION && out_r.slp_slot == TSLOT_3)
		else $error("sleep transition slot wrong");

	slp_rev_a: assert property (@(posedge clk_sys) disable iff (rst)
		slp_in_slots && !act_hw
		|=> out_r.slp_action == SLP_DISABLE && out_r.slp_slot == 3'(SLP_REV_BASE - $past(sleep_r.slot)))
		else $error("sleep disable slot not reversed");

	slp_hw_a: assert property (@(posedge clk_sys) disable iff (rst)
		slp_in_slots && act_hw |=> out_r.slp_action == SLP_HW_ENTER)
		else $error("hardware sleep entry not chosen");

	freq_lim_a: assert property (@(posedge clk_sys) disable iff (rst)
		avs_read && hit_status && first_cycle && switch_freq_sel == FREQ_LOW
		|=> avs_readdata[STAT_ACT_OVER] == 1'b0 && avs_readdata[STAT_SLP_OVER] == 1'b0)
		else $error("limit flagged at low frequency");

	mode_pass_a: assert property (@(posedge clk_sys) disable iff (rst)
		!rst |=> out_r.slp_mode == $past(sleep_r.mode) && out_r.act_mode == $past(active_r.mode))
		else $error("mode fields not forwarded");

	// Outputs load the decoded reset register values on the first edge after release; the !rst guards repeat the disable iff
	hw1_src_a: assert property (@(posedge clk_sys) disable iff (rst)
		active_r.slot == SLOT_HW1 |=> out_r.act_src == SRC_HW1)
		else $error("hardware enable 1 not selected");

	act_off_a: assert property (@(posedge clk_sys) disable iff (rst)
		active_r.slot == SLOT_NONE |=> out_r.act_src == SRC_OFF && out_r.act_slot == SLOT_NONE)
		else $error("converter not left off");

	slp_keep1_a: assert property (@(posedge clk_sys) disable iff (rst)
		sleep_r.slot == SLP_CODE_KEEP1 |=> out_r.slp_action == SLP_TRANSITION && out_r.slp_slot == TSLOT_1)
		else $error("sleep transition slot 1 wrong");

	slp_keep5_a: assert property (@(posedge clk_sys) disable iff (rst)
		!rst && sleep_r.slot == SLP_CODE_KEEP5 |=> out_r.slp_action == SLP_TRANSITION && out_r.slp_slot == TSLOT_5)
		else $error("sleep transition slot 5 wrong");

	volt_pass_a: assert property (@(posedge clk_sys) disable iff (rst)
		!rst
		|=> out_r.act_volt == $past(active_r.volt) && out_r.slp_volt == $past(sleep_r.volt))
		else $error("voltage codes not forwarded");

	slp_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
		commit_wr && hit_sleep && avs_byteenable[1:0] == 2'h3
		|=> sleep_r == bk2cfg_reg_t'($past(avs_writedata[15:0]) & CFG_WMASK))
		else $error("sleep register write lost");

	// Lane 1 disabled must leave slot and mode alone
	lane_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
		commit_wr && hit_active && !avs_byteenable[1]
		|=> active_r.slot == $past(active_r.slot) && active_r.mode == $past(active_r.mode))
		else $error("disabled byte lane written");

	unmapped_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
		commit_wr && !hit_active && !hit_sleep && !cfg_load.strobe
		|=> $stable(active_r) && $stable(sleep_r))
		else $error("unmapped write changed a register");

	rdata_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		!first_cycle |=> $stable(avs_readdata))
		else $error("read data moved without a request");

	sequence rd_status_s;
		avs_read && hit_status && first_cycle;
	endsequence
	sequence rd_cfg_s;
		avs_read && first_cycle && (hit_active || hit_sleep);
	endsequence

	rd_active_a: assert property (@(posedge clk_sys) disable iff (rst)
		rd_cfg_s ##0 hit_active
		|=> avs_readdata == {16'h0000, 16'($past(active_r)) & CFG_WMASK})
		else $error("active register read wrong");

	rd_sleep_a: assert property (@(posedge clk_sys) disable iff (rst)
		rd_cfg_s ##0 hit_sleep
		|=> avs_readdata == {16'h0000, 16'($past(sleep_r)) & CFG_WMASK})
		else $error("sleep register read wrong");

	stat_freq_a: assert property (@(posedge clk_sys) disable iff (rst)
		rd_status_s
		|=> avs_readdata[STAT_FREQ_LSB +: $bits(switch_freq_sel)] == $past(switch_freq_sel))
		else $error("frequency field not reported");

	act_over_a: assert property (@(posedge clk_sys) disable iff (rst)
		rd_status_s ##0 (high_freq && active_r.volt > VCODE_HIFREQ_MAX)
		|=> avs_readdata[STAT_ACT_OVER])
		else $error("active limit not flagged");

	slp_over_a: assert property (@(posedge clk_sys) disable iff (rst)
		rd_status_s ##0 (high_freq && sleep_r.volt > VCODE_HIFREQ_MAX)
		|=> avs_readdata[STAT_SLP_OVER])
		else $error("sleep limit not flagged");

	load_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
		cfg_load.strobe && !(commit_wr && hit_active)
		|=> active_r.slot == $past(active_r.slot) && active_r.mode == $past(active_r.mode))
		else $error("config store load touched slot or mode");

	act_lvl_a: assert property (@(posedge clk_sys) disable iff (rst)
		!rst && active_r.volt > VCODE_FLOOR && active_r.volt < VCODE_CEIL
		|=> active_volt_level > VOLT_MIN && active_volt_level < VOLT_MAX)
		else $error("active level outside ramp");

endmodule : bk2cfg_regs

/* bench/tb.sv */
// Self-checking bench for the buck 2 active and sleep configuration registers
module tb import bk2cfg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [AVS_AW-1:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [AVS_DW-1:0] avs_writedata;
	logic [AVS_DW-1:0] avs_readdata;
	logic [3:0] avs_byteenable;
	logic avs_waitrequest;
	logic [1:0] switch_freq_sel;
	bk2cfg_load_t cfg_load;
	bk2cfg_out_t cfg_out;
	logic [14:0] active_volt_level;
	logic [14:0] sleep_volt_level;
	int n_errors = 0;
	int samples_checked = 0;
	logic [31:0] exp_q[$];

	always #50 clk_sys = ~clk_sys;

	bk2cfg_regs dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .switch_freq_sel(switch_freq_sel),
		.cfg_load(cfg_load), .cfg_out(cfg_out), .active_volt_level(active_volt_level),
		.sleep_volt_level(sleep_volt_level));

	task automatic report_and_stop();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: read %h expected %h", $time, got, exp);
		end
	endtask : check_rd

	task automatic check_out(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: output %h expected %h", $time, got, exp);
		end
	endtask : check_out

	// Read data taken at the rising edge where waitrequest is seen low
	always @(posedge clk_sys) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			if (exp_q.size() == 0) begin
				check_rd(avs_readdata, 32'hFFFFFFFF);
			end else begin
				check_rd(avs_readdata, exp_q.pop_front());
			end
		end
	end

	task automatic bus(input logic wr, input logic [AVS_AW-1:0] a, input logic [31:0] d, input logic [3:0] be);
		int i;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= ~wr;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0) break;
		end
		if (i == 20) begin
			n_errors++;
			$display("mismatch at %0t: bus wait ran out", $time);
			report_and_stop();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [AVS_AW-1:0] a, input logic [15:0] d);
		bus(1'b1, a, {16'h0000, d}, 4'hF);
	endtask : wr

	task automatic rd(input logic [AVS_AW-1:0] a, input logic [15:0] exp);
		exp_q.push_back({16'h0000, exp});
		bus(1'b0, a, 32'h00000000, 4'hF);
	endtask : rd

	// Decoded outputs trail a commit by two registered stages
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : settle

	function automatic logic [14:0] lvl(input logic [6:0] c);
		if (c <= VCODE_FLOOR) return VOLT_MIN;
		if (c >= VCODE_CEIL) return VOLT_MAX;
		return VOLT_MIN + 15'(c - VCODE_FLOOR) * VOLT_STEP;
	endfunction : lvl

	function automatic logic [15:0] exp_src(input logic [2:0] a);
		if (a == SLOT_NONE) return 16'(SRC_OFF);
		if (a == SLOT_HW1) return 16'(SRC_HW1);
		if (a == SLOT_HW2) return 16'(SRC_HW2);
		return 16'(SRC_SLOT);
	endfunction : exp_src

	function automatic logic [15:0] exp_slp(input logic [2:0] a, input logic [2:0] s, input logic want_slot);
		if (s == 3'h0 || s >= 3'h6) return want_slot ? ((s == 3'h0) ? 16'h5 : (s == 3'h6) ? 16'h3 : 16'h1) :
			16'(SLP_TRANSITION);
		if (want_slot) return 16'(3'h6 - s);
		return (a >= 3'h6) ? 16'(SLP_HW_ENTER) : 16'(SLP_DISABLE);
	endfunction : exp_slp

	initial begin
		logic [2:0] a;
		logic [2:0] s;
		logic [6:0] v;
		logic [1:0] m;
		logic [1:0] f;
		logic [4:0] hi;
		logic [6:0] codes[8] = '{7'h00, 7'h08, 7'h09, 7'h48, 7'h49, 7'h67, 7'h68, 7'h7F};
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		avs_byteenable = 4'hF;
		switch_freq_sel = FREQ_LOW;
		cfg_load = '0;
		void'($urandom(1970));
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		settle();
		check_out(cfg_out.act_src, SRC_OFF);
		check_out(cfg_out.act_mode, MODE_AUTO);
		check_out(cfg_out.slp_mode, MODE_HYST);
		check_out(cfg_out.slp_slot, TSLOT_5);
		check_out(active_volt_level, VOLT_MIN);
		check_out(sleep_volt_level, VOLT_MIN);
		rd(ADDR_ACTIVE, ACTIVE_RST);
		rd(ADDR_SLEEP, SLEEP_RST);
		bus(1'b1, ADDR_ACTIVE, 32'h0000FFFF, 4'h1);
		rd(ADDR_ACTIVE, 16'h017F);
		wr(ADDR_ACTIVE, 16'hFFFF);
		rd(ADDR_ACTIVE, CFG_WMASK);
		wr(ADDR_ACTIVE + 18'h00010, 16'hFFFF);
		rd(ADDR_ACTIVE + 18'h00010, UNMAPPED_RDATA);
		rd(ADDR_ACTIVE, CFG_WMASK);
		for (int k = 0; k < 64; k++) begin
			a = 3'(k >> 3);
			s = 3'(k);
			m = 2'($urandom);
			v = 7'($urandom);
			wr(ADDR_ACTIVE, {a, 3'h0, m, 1'b0, v});
			wr(ADDR_SLEEP, {s, 3'h0, ~m, 1'b0, ~v});
			settle();
			check_out(cfg_out.act_src, exp_src(a));
			if (a >= SLOT_FIRST && a <= SLOT_LAST) check_out(cfg_out.act_slot, a);
			else check_out(cfg_out.act_slot, SLOT_NONE);
			check_out(cfg_out.act_mode, m);
			check_out(cfg_out.act_volt, v);
			check_out(active_volt_level, lvl(v));
			check_out(cfg_out.slp_action, exp_slp(a, s, 1'b0));
			check_out(cfg_out.slp_slot, exp_slp(a, s, 1'b1));
			check_out(cfg_out.slp_mode, 2'(~m));
			check_out(cfg_out.slp_volt, 7'(~v));
			check_out(sleep_volt_level, lvl(~v));
		end
		wr(ADDR_SLEEP, 16'h0049);
		for (int k = 0; k < 16; k++) begin
			f = k[3] ? FREQ_HIGH : FREQ_LOW;
			switch_freq_sel <= f;
			wr(ADDR_ACTIVE, {3'h0, 3'h0, MODE_LDO, 1'b0, codes[k[2:0]]});
			settle();
			check_out(active_volt_level, lvl(codes[k[2:0]]));
			rd(ADDR_STATUS, {12'h000, f == FREQ_HIGH, codes[k[2:0]] > VCODE_HIFREQ_MAX && f == FREQ_HIGH, f});
		end
		hi = 5'($urandom);
		@(posedge clk_sys);
		cfg_load <= '{1'b1, hi};
		@(posedge clk_sys);
		cfg_load <= '0;
		settle();
		check_out(cfg_out.act_volt, {hi, 2'h0});
		rd(ADDR_ACTIVE, {8'h02, 1'b0, hi, 2'h0});
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd(ADDR_ACTIVE, ACTIVE_RST);
		rd(ADDR_SLEEP, SLEEP_RST);
		report_and_stop();
	end
endmodule : tb
